// ==== rtl/tis_status.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Transceiver interrupt status word
// ----------------------------------------------------------------------------
// Summary of operation
// - Reading status clears flags, releases request
// - Bit 15 shows oscillator out of lock
// - Packet mode bit 14: burst overran memory
// - Stream mode bit 14: tx stream done
// - Packet mode bit 13: memory arbiter conflict
// - Stream mode bit 13: rx stream done
// - Stream mode bit 12 set on rx word overrun
// - Stream mode bit 12 set on tx word underrun
// - Bit 10 on attention falling edge or power-up
// - Doze compare two match sets bit 9, wakes
// - Bit 8 set on compare one match
// - Packet mode bit 7: rx packet done
// - Stream mode bit 7: length, then words ready
// - Stream select picks meaning of shared bits
// - Bit 6: tx done or tx word needed
// - Bit 2: compare two or short compare
module tis_status
(
   input  wire logic        clock,              // Core clock, 100 MHz
   input  wire logic        rstn,               // Async reset, active low
   // Register read port
   input  wire logic        reg_rd,             // Read strobe, one cycle
   input  wire logic [5:0]  reg_addr,           // Register index
   output logic [15:0]      reg_rdata,          // Read data, valid cycle after strobe
   // Configuration from other registers
   input  wire logic [15:0] irq_mask,           // Per-flag request enables
   input  wire logic        stream_mode,        // Stream operation selected
   input  wire logic        alt_compare_en,     // Short compare in addition to compare two
   input  wire logic [23:0] compare_one_value,  // Compare one value
   input  wire logic [23:0] compare_two_value,  // Compare two value
   input  wire logic [15:0] alternate_short_compare, // Short compare value
   input  wire logic [23:0] event_timer,        // Event timer count
   // Core events, same clock
   input  wire logic        first_local_oscillator_unlock, // Level, out of lock
   input  wire logic        ram_burst_overflow, // Pulse
   input  wire logic        ram_arb_conflict,   // Pulse
   input  wire logic        tx_stream_done,     // Pulse
   input  wire logic        rx_stream_done,     // Pulse
   input  wire logic        rx_word_overrun,    // Pulse
   input  wire logic        tx_word_underrun,   // Pulse
   input  wire logic        powerup_done,       // Pulse after reset release
   input  wire logic        rx_packet_done,     // Pulse
   input  wire logic        rx_length_ready,    // Pulse, first stream word
   input  wire logic        rx_word_ready,      // Pulse, later stream words
   input  wire logic        tx_packet_done,     // Pulse
   input  wire logic        tx_word_needed,     // Pulse
   input  wire logic        in_doze,            // Doze state level
   // Pins
   input  wire logic        attn_n,             // Attention pin, async, active low
   output logic             irq_n,              // Interrupt request, active low
   output logic             doze_wake           // Pulse: leave doze for idle
);

   // ----------------------------------------------------------------------------
   // Shared-bit selection
   // ----------------------------------------------------------------------------
   function automatic logic pick(input logic strm, input logic pkt_ev, input logic strm_ev);
      pick = strm ? strm_ev : pkt_ev;
   endfunction

   logic [15:0] flags_q;                        // Sticky flags
   logic [15:0] flags_d;
   logic [15:0] set_vec;                        // Events this cycle
   logic [15:0] rdata_q;                        // Registered read data
   logic [15:0] rdata_d;
   logic        irq_n_q;                        // Registered request pin
   logic        irq_n_d;
   logic        wake_q;                         // Registered doze wake pulse
   logic        wake_d;
   logic        attn_s1_q;                      // Synchroniser first stage
   logic        attn_s2_q;                      // Synchroniser second stage
   logic        attn_s3_q;                      // Edge history
   logic        hit_read;                       // Status word read this cycle
   logic        cmp1_hit;                       // Compare one fresh match
   logic        cmp2_hit;                       // Compare two fresh match
   logic        alt_hit;                        // Short compare fresh match

   // ----------------------------------------------------------------------------
   // Timer comparators
   // ----------------------------------------------------------------------------
   tis_cmp u_cmp1 (.clock(clock), .rstn(rstn), .enable(1'b1), .short_mode(1'b0),
                   .timer(event_timer), .value(compare_one_value), .hit(cmp1_hit));
   tis_cmp u_cmp2 (.clock(clock), .rstn(rstn), .enable(1'b1), .short_mode(1'b0),
                   .timer(event_timer), .value(compare_two_value), .hit(cmp2_hit));
   tis_cmp u_alt  (.clock(clock), .rstn(rstn), .enable(alt_compare_en), .short_mode(1'b1),
                   .timer(event_timer), .value({8'h00, alternate_short_compare}),
                   .hit(alt_hit));

   // ----------------------------------------------------------------------------
   // Attention pin synchroniser
   // ----------------------------------------------------------------------------
   // Two stages before use, third stage only for the falling edge
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         attn_s1_q <= tis_pkg::ATTN_IDLE;
         attn_s2_q <= tis_pkg::ATTN_IDLE;
         attn_s3_q <= tis_pkg::ATTN_IDLE;
      end
      else
      begin
         attn_s1_q <= attn_n;
         attn_s2_q <= attn_s1_q;
         attn_s3_q <= attn_s2_q;
      end
   end

   // ----------------------------------------------------------------------------
   // Flag set, clear and read
   // ----------------------------------------------------------------------------
   assign hit_read = reg_rd && (reg_addr == tis_pkg::FLAGS_ADDR);

   // Next flags; a set in the clearing cycle survives the clear
   always_comb
   begin
      set_vec = 16'h0000;
      set_vec[tis_pkg::B_LOCK]     = first_local_oscillator_unlock;
      set_vec[tis_pkg::B_RAMERR]   = pick(stream_mode, ram_burst_overflow,
                                          tx_stream_done);
      set_vec[tis_pkg::B_ARB]      = pick(stream_mode, ram_arb_conflict,
                                          rx_stream_done);
      set_vec[tis_pkg::B_STRM_ERR] = stream_mode && (rx_word_overrun || tx_word_underrun);
      set_vec[tis_pkg::B_ATTN]     = (!attn_s2_q && attn_s3_q) || powerup_done;
      set_vec[tis_pkg::B_DOZE]     = in_doze && cmp2_hit;
      set_vec[tis_pkg::B_CMP1]     = cmp1_hit;
      set_vec[tis_pkg::B_RX]       = pick(stream_mode, rx_packet_done,
                                          rx_length_ready || rx_word_ready);
      set_vec[tis_pkg::B_TX]       = pick(stream_mode, tx_packet_done,
                                          tx_word_needed);
      set_vec[tis_pkg::B_CMP2]     = cmp2_hit || alt_hit;
      // Read clears everything held so far
      if (hit_read)
         flags_d = set_vec;
      else
         flags_d = flags_q | set_vec;
      // Read returns the word as it stood before the clear
      if (hit_read)
         rdata_d = flags_q;
      else
         rdata_d = 16'h0000;
      // Request follows the next flags so pin and word change together
      irq_n_d = ~|(flags_d & irq_mask);
      wake_d  = in_doze && cmp2_hit;
   end

   // Register all state
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         flags_q <= tis_pkg::FLAGS_RST;
         rdata_q <= tis_pkg::RDATA_RST;
         irq_n_q <= 1'b1;
         wake_q  <= 1'b0;
      end
      else
      begin
         flags_q <= flags_d;
         rdata_q <= rdata_d;
         irq_n_q <= irq_n_d;
         wake_q  <= wake_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign irq_n     = irq_n_q;
   assign doze_wake = wake_q;

   // ----------------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence s_attn_fall;
      attn_s2_q ##1 !attn_s2_q;
   endsequence

   // Wake stands for exactly one cycle beside the doze flag
   sequence s_wake_pulse;
      doze_wake && flags_q[9] ##1 !doze_wake;
   endsequence

   a_read_clears: assert property (hit_read && set_vec == 16'h0000 |=> flags_q == 16'h0000)
      else $error("status read did not clear flags");
   a_read_value: assert property (hit_read |=> reg_rdata == $past(flags_q))
      else $error("read data is not the pre-clear word");
   // The pin was registered with the mask of the previous edge
   a_irq_pin: assert property (irq_n == !(|(flags_q & $past(irq_mask))))
      else $error("request pin disagrees with enabled flags");
   a_lock_bit: assert property (first_local_oscillator_unlock |=> flags_q[15])
      else $error("lock bit not set while unlocked");
   a_ram_overflow: assert property (!stream_mode && ram_burst_overflow |=> flags_q[14])
      else $error("burst overflow not flagged");
   a_tx_sdone: assert property (stream_mode && tx_stream_done |=> flags_q[14])
      else $error("tx stream done not flagged");
   a_arb_conflict: assert property (!stream_mode && ram_arb_conflict |=> flags_q[13])
      else $error("arbiter conflict not flagged");
   a_rx_sdone: assert property (stream_mode && rx_stream_done |=> flags_q[13])
      else $error("rx stream done not flagged");
   a_mux_excl: assert property (!stream_mode && rx_stream_done && !ram_arb_conflict
                                && !hit_read && !flags_q[13] |=> !flags_q[13])
      else $error("stream event flagged in packet mode");
   a_overrun: assert property (stream_mode && rx_word_overrun |=> flags_q[12])
      else $error("overrun not flagged");
   a_underrun: assert property (stream_mode && tx_word_underrun |=> flags_q[12])
      else $error("underrun not flagged");
   a_attn_flag: assert property (s_attn_fall |=> flags_q[10])
      else $error("attention fall not flagged");
   a_powerup: assert property (powerup_done |=> flags_q[10])
      else $error("power-up not flagged");
   a_doze_wake: assert property (in_doze && cmp2_hit |=> s_wake_pulse)
      else $error("doze match did not wake");
   a_cmp1_flag: assert property (cmp1_hit |=> flags_q[8])
      else $error("compare one not flagged");
   a_rx_pkt: assert property (!stream_mode && rx_packet_done |=> flags_q[7])
      else $error("rx packet done not flagged");
   a_rx_word: assert property (stream_mode && (rx_length_ready || rx_word_ready)
                               |=> flags_q[7])
      else $error("rx stream word not flagged");
   a_tx_bit: assert property (pick(stream_mode, tx_packet_done, tx_word_needed)
                              |=> flags_q[6])
      else $error("tx bit 6 not flagged");
   a_cmp2_flag: assert property (cmp2_hit || alt_hit |=> flags_q[2])
      else $error("compare two not flagged");

endmodule

// ==== common/tis_pkg.sv ====
// ----------------------------------------------------------------------------
// Interrupt status constants
// ----------------------------------------------------------------------------
package tis_pkg;

   // Register port geometry
   localparam int          ADDR_W      = 6;               // Register index width
   localparam int          DATA_W      = 16;              // Register word width
   localparam int          TIMER_W     = 24;              // Event timer width
   localparam int          SHORT_W     = 16;              // Alternate compare width

   // Status word location and reset value
   localparam logic [5:0]  FLAGS_ADDR  = 6'h24;           // Interrupt flags register
   localparam logic [15:0] FLAGS_RST   = 16'h0000;        // All flags clear after reset
   localparam logic [15:0] RDATA_RST   = 16'h0000;        // Read data after reset

   // Flag positions
   localparam int          B_LOCK      = 15;              // Oscillator out of lock
   localparam int          B_RAMERR    = 14;              // Burst overflow / tx stream done
   localparam int          B_ARB       = 13;              // Arbiter conflict / rx stream done
   localparam int          B_STRM_ERR  = 12;              // Stream overrun or underrun
   localparam int          B_ATTN      = 10;              // Attention or power-up complete
   localparam int          B_DOZE      = 9;               // Doze wake-up match
   localparam int          B_CMP1      = 8;               // Compare one match
   localparam int          B_RX        = 7;               // Rx packet done / rx word ready
   localparam int          B_TX        = 6;               // Tx packet done / tx word needed
   localparam int          B_CMP2      = 2;               // Compare two match

   // Pin synchroniser idle level
   localparam logic        ATTN_IDLE   = 1'b1;            // Attention pin is active low

endpackage

// ==== rtl/tis_cmp.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Event timer comparator, one pulse per match
// ----------------------------------------------------------------------------
module tis_cmp
(
   input  wire logic        clock,         // Core clock
   input  wire logic        rstn,          // Async reset, active low
   input  wire logic        enable,        // Comparator armed
   input  wire logic        short_mode,    // Compare only the low 16 bits
   input  wire logic [23:0] timer,         // Current event timer count
   input  wire logic [23:0] value,         // Compare value
   output logic             hit            // One-cycle pulse on a fresh match
);

   logic eq;                               // Equality this cycle
   logic eq_q;                             // Equality last cycle
   logic eq_d;

   // Equality, narrowed when the short compare is chosen
   always_comb
   begin
      if (short_mode)
         eq = enable && (timer[tis_pkg::SHORT_W-1:0] == value[tis_pkg::SHORT_W-1:0]);
      else
         eq = enable && (timer == value);
      eq_d = eq;
   end

   // A stopped timer would hold equality; pulse only on its first cycle
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         eq_q <= 1'b0;
      else
         eq_q <= eq_d;
   end

   assign hit = eq && !eq_q;

endmodule

// ==== testbench/tis_host.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Host microcontroller reading the status word
// ----------------------------------------------------------------------------
module tis_host
(
   input  wire logic        clock,   // Core clock
   input  wire logic        rstn,    // Reset, active low
   input  wire logic [1:0]  pace,    // Read rate: 1 slow, 2 prompt
   input  wire logic        strm,    // Stream meanings selected
   input  wire logic [15:0] rdata,   // Device read data
   output logic             rd,      // Read strobe, one cycle
   output logic [5:0]       addr     // Register index
);
   integer seed = 32'h1F82FB55;      // Fixed seed
   integer n_pkt = 0;                // Received packets seen
   integer n_word = 0;               // Stream words seen

   // Reads change off the sampling edge; none while reset is held.
   // Reads may run back to back, and some go to unmapped places.
   always @(negedge clock)
   begin
      // Data is non-zero only right after a flags read
      if (rdata[7])
      begin
         // Bit 7 meaning follows the mode selection
         if (strm)
            n_word++;
         else
            n_pkt++;
      end
      rd = rstn && (($random(seed) & 7) < (pace == 2'h2 ? 4 : 1));
      addr = (($random(seed) & 3) == 0) ? 6'($random(seed)) : 6'h24;
   end
endmodule

// ==== testbench/test_tis_status.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Self-checking bench for the interrupt status word
// ----------------------------------------------------------------------------
module test_tis_status;
   logic        clock = 1'b0;       // Core clock
   logic        rstn = 1'b0;        // Reset, active low
   logic        rd;                 // Host read strobe
   logic [5:0]  addr;               // Host register index
   logic [15:0] rdata;              // Read data
   logic [15:0] mask = 16'h0000;    // Request enables
   logic        strm = 1'b0;        // Stream operation
   logic        alt = 1'b0;         // Short compare enable
   logic [23:0] c1 = 24'h000000;    // Compare one value
   logic [23:0] c2 = 24'h000000;    // Compare two value
   logic [15:0] sh = 16'h0000;      // Short compare value
   logic [23:0] tmr = 24'h000000;   // Event timer, kept below 32
   logic [11:0] ev = 12'h000;       // Event pulses
   logic        unl = 1'b0;         // Oscillator out of lock
   logic        doze = 1'b0;        // Doze state
   logic        attn_n = 1'b1;      // Attention pin
   logic        irq_n;              // Request pin
   logic        wake;               // Doze wake pulse
   logic [1:0]  pace = 2'h2;        // Host read rate
   logic [15:0] set;                // Model: flags raised this edge
   logic [15:0] mflags;             // Model: flags word
   logic [15:0] mrd;                // Model: read data
   logic        mirq;               // Model: request pin
   logic        mwake;              // Model: wake pulse
   logic [3:0]  hist;               // Model: attention pin history
   logic        e1;                 // Model: compare one equal now
   logic        e2;                 // Model: compare two equal now
   logic        ea;                 // Model: short compare equal now
   logic        e1_q;               // Model: compare one equal last edge
   logic        e2_q;               // Model: compare two equal last edge
   logic        ea_q;               // Model: short compare equal last edge
   integer      seed = 32'h1F82FB55; // Fixed seed
   integer      mismatches = 0;     // Failed comparisons
   integer      n_tests = 0;        // Comparisons made
   integer      cyc = 0;            // Cycle count for the hang limit
   integer      p;                  // Phase index

   always #5 clock = ~clock;

   tis_status u_dut (.clock(clock), .rstn(rstn), .reg_rd(rd), .reg_addr(addr),
      .reg_rdata(rdata), .irq_mask(mask), .stream_mode(strm), .alt_compare_en(alt),
      .compare_one_value(c1), .compare_two_value(c2), .alternate_short_compare(sh),
      .event_timer(tmr), .first_local_oscillator_unlock(unl),
      .ram_burst_overflow(ev[0]), .ram_arb_conflict(ev[1]), .tx_stream_done(ev[2]),
      .rx_stream_done(ev[3]), .rx_word_overrun(ev[4]), .tx_word_underrun(ev[5]),
      .powerup_done(ev[6]), .rx_packet_done(ev[7]), .rx_length_ready(ev[8]),
      .rx_word_ready(ev[9]), .tx_packet_done(ev[10]), .tx_word_needed(ev[11]),
      .in_doze(doze), .attn_n(attn_n), .irq_n(irq_n), .doze_wake(wake));

   tis_host u_host (.clock(clock), .rstn(rstn), .pace(pace), .strm(strm),
      .rdata(rdata), .rd(rd), .addr(addr));

   // ------------------------------------------------------------------------
   // Reference model, one step per rising edge
   // ------------------------------------------------------------------------
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         mflags = 16'h0000;
         mrd = 16'h0000;
         mirq = 1'b1;
         mwake = 1'b0;
         hist = 4'hF;
         e1_q = 1'b0;
         e2_q = 1'b0;
         ea_q = 1'b0;
      end
      else
      begin
         set = 16'h0000;
         set[15] = unl;
         set[14] = strm ? ev[2] : ev[0];
         set[13] = strm ? ev[3] : ev[1];
         set[12] = strm & (ev[4] | ev[5]);
         // Pin fall seen through two sync stages and an edge detector
         set[10] = ev[6] | (!hist[1] & hist[2]);
         hist = {hist[2:0], attn_n};
         // A match counts once, on the first edge of equality
         e1 = (tmr == c1);
         e2 = (tmr == c2);
         ea = alt & (tmr[15:0] == sh);
         set[9] = doze & e2 & !e2_q;
         set[8] = e1 & !e1_q;
         set[7] = strm ? (ev[8] | ev[9]) : ev[7];
         set[6] = strm ? ev[11] : ev[10];
         set[2] = (e2 & !e2_q) | (ea & !ea_q);
         e1_q = e1;
         e2_q = e2;
         ea_q = ea;
         mrd = (rd && addr == 6'h24) ? mflags : 16'h0000;
         mflags = ((rd && addr == 6'h24) ? 16'h0000 : mflags) | set;
         mirq = ~|(mflags & mask);
         mwake = set[9];
      end
   end

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (exp !== got)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic results;
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Hang limit, well above the 2400 cycles the phases need
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         mismatches++;
         results;
      end
   end

   // ------------------------------------------------------------------------
   // Phases: every mode pair, slow and prompt host, a reset in mid-run
   // ------------------------------------------------------------------------
   initial
   begin
      repeat (5) @(negedge clock);
      rstn = 1'b1;
      for (p = 0; p < 8; p++)
      begin
         strm = p[0];
         alt = p[1];
         pace = p[2] ? 2'h1 : 2'h2;
         mask = 16'($random(seed));
         c1 = 24'($random(seed)) & 24'h00001F;
         sh = 16'($random(seed)) & 16'h001F;
         // Short value equals compare two so either reading of bit 2 agrees
         c2 = alt ? {8'h00, sh} : (24'($random(seed)) & 24'h00001F);
         if (p == 4)
         begin
            rstn = 1'b0;
            repeat (5) @(negedge clock);
            rstn = 1'b1;
         end
         repeat (300)
         begin
            @(negedge clock);
            chk("read data", mrd, rdata);
            chk("request pin", 16'(mirq), 16'(irq_n));
            chk("doze wake", 16'(mwake), 16'(wake));
            // Timer steps every cycle, so each equality is a fresh match
            tmr = {19'h0, tmr[4:0] + 5'h01};
            ev = 12'($random(seed) & $random(seed) & $random(seed));
            unl = (($random(seed) & 63) == 0) ? ~unl : unl;
            doze = 1'($random(seed));
            attn_n = (($random(seed) & 31) == 0) ? ~attn_n : attn_n;
         end
         $display("Phase %0d done, stream %0d, short %0d", p, strm, alt);
      end
      results;
   end
endmodule
